// File: pkg/dhr_pkg.sv
// Constants and carrier types shared by the display hardware reset sequencer.
package dhr_pkg;

  // ----------------------------------------------------------------
  // System clock and spike filter timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SPIKE_REJECT_NS = 5000;
  localparam int unsigned SPIKE_REJECT_CYC =
    (SPIKE_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W = 10;
  localparam logic [FILT_W-1:0] SPIKE_LAST = FILT_W'(SPIKE_REJECT_CYC - 1);

  // ----------------------------------------------------------------
  // Blanking sequence bound when reset hits an awake display
  // ----------------------------------------------------------------
  localparam int unsigned BLANK_MAX_MS = 120;
  localparam int unsigned BLANK_MAX_CYC = BLANK_MAX_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned BLANK_W = 24;

  // ----------------------------------------------------------------
  // Settings storage and load sequence
  // ----------------------------------------------------------------
  localparam int unsigned NVM_BYTES = 8;
  localparam int unsigned NVM_AW = 3;
  localparam logic [NVM_AW-1:0] NVM_LAST = 3'h7;
  // Stored image: three identity bytes, electrode level, four trim bytes.
  // The identity bytes are arbitrary values.
  localparam logic [63:0] NVM_IMAGE = 64'h5A_A5_3C_40_12_34_56_78;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [2:0] LINK_BIT_FIRST = 3'h0;
  localparam logic [2:0] LINK_BIT_LAST = 3'h7;
  localparam logic [7:0] CMD_SLEEP_IN = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;

  // ----------------------------------------------------------------
  // Carrier types and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] id_bytes;
    logic [7:0] common_electrode_level;
    logic [31:0] panel_trim;
  } dhr_settings_t;

  typedef struct packed {
    logic [7:0] code;
    logic is_param;
  } dhr_cmd_t;

  localparam dhr_settings_t SETTINGS_DEFAULT = 64'h0000_0000_0000_0000;
  localparam dhr_cmd_t CMD_DEFAULT = 9'h000;

endpackage : dhr_pkg

// File: testbench/dhr_host_model.sv
// Host controller model driving the reset pin and the 4-line serial link.
`timescale 1ns/1ps
`default_nettype none

module dhr_host_model #(
  parameter int unsigned CMD_WAIT_NS = 5000000,
  parameter int unsigned WAKE_WAIT_NS = 120000000
) (
  // System clock used to time the reset pulse
  input wire logic i_sys_clk,
  // Pins towards the display
  output logic o_hw_reset_n,
  output logic o_link_clk,
  output logic o_chip_select_n,
  output logic o_cmd_or_param_select,
  output logic o_sda
);
  realtime rel_time = 0;

  initial begin
    o_hw_reset_n = 1'b1;
    o_link_clk = 1'b0;
    o_chip_select_n = 1'b1;
    o_cmd_or_param_select = 1'b0;
    o_sda = 1'b0;
  end

  // Low pulse counted in system cycles, with an optional 30-cycle high spike.
  task automatic reset_pulse(input int unsigned low_cyc, input int unsigned spike_at);
    @(negedge i_sys_clk);
    o_hw_reset_n = 1'b0;
    for (int unsigned i = 1; i < low_cyc; i++) begin
      @(negedge i_sys_clk);
      o_hw_reset_n = (spike_at != 0) && (i >= spike_at) && (i < spike_at + 30);
    end
    @(negedge i_sys_clk);
    o_hw_reset_n = 1'b1;
    rel_time = $realtime;
  endtask : reset_pulse

  // Waits are skipped only when a byte is pushed in during a held reset on purpose.
  task automatic send_byte(input logic [7:0] data, input logic dc);
    realtime until_t;
    until_t = rel_time + ((!dc && data == dhr_pkg::CMD_SLEEP_OUT) ?
      WAKE_WAIT_NS : CMD_WAIT_NS);
    if (o_hw_reset_n && until_t > $realtime) #(until_t - $realtime);
    #7;
    o_chip_select_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_sda = data[i];
      o_cmd_or_param_select = (i == 0) ? dc : !o_cmd_or_param_select;
      #24 o_link_clk = 1'b1;
      #24 o_link_clk = 1'b0;
    end
    #20 o_chip_select_n = 1'b1;
    o_sda = !o_sda;
    o_cmd_or_param_select = !o_cmd_or_param_select;
    #40;
  endtask : send_byte
endmodule : dhr_host_model
`default_nettype wire

// File: testbench/dhr_reset_seq_props.sv
// Concurrent checks on the ports of the display hardware reset sequencer.
`timescale 1ns/1ps
`default_nettype none

module dhr_reset_seq_props #(
  parameter int unsigned BLANK_CYC = 200
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Watched ports
  input wire logic i_hw_reset_n,
  input wire logic o_display_blank,
  input wire logic o_cancel_busy,
  input wire logic o_sleep_in,
  input wire dhr_pkg::dhr_settings_t o_settings,
  input wire logic o_cmd_valid,
  input wire dhr_pkg::dhr_cmd_t o_cmd
);
  localparam int unsigned AWAKE_MAX = BLANK_CYC + 600;
  logic [31:0] low_cnt_reg;
  logic [31:0] high_cnt_reg;
  logic [31:0] rel_cnt_reg;

  // Counts runs of the pin level and of busy time after the pin came back high.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_reg <= 32'h0;
      high_cnt_reg <= 32'h0;
      rel_cnt_reg <= 32'h0;
    end else begin
      low_cnt_reg <= i_hw_reset_n ? 32'h0 : low_cnt_reg + 32'h1;
      high_cnt_reg <= i_hw_reset_n ? high_cnt_reg + 32'h1 : 32'h0;
      rel_cnt_reg <= (o_cancel_busy && i_hw_reset_n) ? rel_cnt_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_long_low: assert property (low_cnt_reg == 32'd520 |-> o_cancel_busy)
    else $error("long reset pulse did not start a reset");
  a_spike_reject: assert property ($rose(o_cancel_busy) |-> high_cnt_reg < 32'd16)
    else $error("reset started without a long low pulse");
  a_busy_blank: assert property (o_cancel_busy |-> o_display_blank)
    else $error("display not blanked during reset");
  a_blank_follow: assert property (!o_cancel_busy |-> o_display_blank == o_sleep_in)
    else $error("blanking does not follow sleep state");
  a_rise_defaults: assert property ($rose(o_cancel_busy) |->
    o_settings == dhr_pkg::SETTINGS_DEFAULT && o_sleep_in)
    else $error("reset defaults not applied");
  a_load_image: assert property ($fell(o_cancel_busy) |->
    o_settings == dhr_pkg::NVM_IMAGE)
    else $error("settings not loaded at end of reset");
  a_awake_bound: assert property (rel_cnt_reg <= AWAKE_MAX)
    else $error("reset cancel period too long");
  a_cmd_single: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("byte strobe longer than one cycle");
  a_wake_clears: assert property (o_cmd_valid && o_cmd == {dhr_pkg::CMD_SLEEP_OUT, 1'b0}
    |-> !o_sleep_in && !o_display_blank)
    else $error("wake command did not leave sleep");
  a_busy_drop: assert property (o_cancel_busy |-> !o_cmd_valid)
    else $error("byte accepted during reset");

  c_busy_rise: cover property ($rose(o_cancel_busy));
  c_load_done: cover property ($fell(o_cancel_busy));
  c_wake: cover property (o_cmd_valid && !o_sleep_in);
endmodule : dhr_reset_seq_props
`default_nettype wire

// File: testbench/dhr_reset_seq_test.sv
// Self-checking testbench of the display hardware reset sequencer.
`timescale 1ns/1ps
`default_nettype none

module dhr_reset_seq_test;
  localparam int unsigned BLANK = 3000;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic hw_reset_n, link_clk, cs_n, dc, sda, blank, busy, sleep_in, cmd_valid;
  dhr_pkg::dhr_settings_t settings;
  dhr_pkg::dhr_cmd_t cmd;
  dhr_pkg::dhr_cmd_t exp_q[$];
  int miscompares = 0;
  int num_checks = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  dhr_host_model #(.CMD_WAIT_NS(10000), .WAKE_WAIT_NS(15000)) host_u (
    .i_sys_clk(i_sys_clk), .o_hw_reset_n(hw_reset_n), .o_link_clk(link_clk),
    .o_chip_select_n(cs_n), .o_cmd_or_param_select(dc), .o_sda(sda));

  dhr_reset_seq #(.BLANK_CYC(BLANK)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hw_reset_n(hw_reset_n),
    .i_link_clk(link_clk), .i_chip_select_n(cs_n), .i_cmd_or_param_select(dc),
    .i_sda(sda), .o_display_blank(blank), .o_cancel_busy(busy), .o_sleep_in(sleep_in),
    .o_settings(settings), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

  // ----------------------------------------------------------------
  // Compare and report tasks
  // ----------------------------------------------------------------
  task automatic chk_st(input logic [67:0] got, input logic [67:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_st

  task automatic chk_cmd(input dhr_pkg::dhr_cmd_t got, input dhr_pkg::dhr_cmd_t exp);
    chk_st(68'(got), 68'(exp));
  endtask : chk_cmd

  task automatic final_report;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic wait_busy(input logic val, input int unsigned limit, output int unsigned n);
    n = 0;
    while (busy !== val && n < limit) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask : wait_busy

  task automatic drain;
    for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(negedge i_sys_clk);
    repeat (2) @(negedge i_sys_clk);
  endtask : drain

  // Every accepted byte is taken against the oldest expected one.
  always @(negedge i_sys_clk) begin
    if (cmd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_cmd(cmd, ~cmd);
      end else begin
        chk_cmd(cmd, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    int unsigned n;
    logic [7:0] b;
    logic d;
    void'($urandom(32'h2fd58e08));
    repeat (12) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    @(negedge i_sys_clk);
    chk_st({blank, busy, sleep_in, settings}, {3'h5, dhr_pkg::SETTINGS_DEFAULT});
    host_u.reset_pulse(480, 0);
    repeat (600) @(negedge i_sys_clk);
    chk_st({blank, busy, sleep_in, settings}, {3'h5, 64'h0});
    b = 8'($urandom);
    fork
      host_u.reset_pulse(1000, 600);
      begin
        repeat (560) @(negedge i_sys_clk);
        chk_st({blank, busy, sleep_in, settings}, {3'h7, 64'h0});
        host_u.send_byte(b, 1'b0);
      end
    join
    wait_busy(1'b0, 2000, n);
    chk_st({(n < 1000), blank, sleep_in, settings}, {3'h7, dhr_pkg::NVM_IMAGE});
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      d = 1'($urandom);
      if (b[7:1] == 7'h08) b = 8'hA5;
      exp_q.push_back({b, d});
      host_u.send_byte(b, d);
    end
    exp_q.push_back({dhr_pkg::CMD_SLEEP_OUT, 1'b0});
    host_u.send_byte(dhr_pkg::CMD_SLEEP_OUT, 1'b0);
    drain();
    chk_st({blank, sleep_in}, 68'h0);
    fork
      host_u.reset_pulse(1000, 0);
      begin
        wait_busy(1'b1, 600, n);
        @(negedge i_sys_clk);
        chk_st({blank, busy, sleep_in, settings}, {3'h7, 64'h0});
      end
    join
    wait_busy(1'b0, 4000, n);
    chk_st({(n > 1000), (n <= BLANK + 600), blank, sleep_in, settings},
      {4'hF, dhr_pkg::NVM_IMAGE});
    exp_q.push_back({dhr_pkg::CMD_SLEEP_OUT, 1'b0});
    host_u.send_byte(dhr_pkg::CMD_SLEEP_OUT, 1'b0);
    drain();
    chk_st({blank, sleep_in}, 68'h0);
    exp_q.push_back({dhr_pkg::CMD_SLEEP_IN, 1'b0});
    host_u.send_byte(dhr_pkg::CMD_SLEEP_IN, 1'b0);
    drain();
    chk_st({blank, sleep_in, 32'(exp_q.size())}, {2'h3, 32'h0});
    final_report();
  end

  initial begin
    #500000;
    miscompares++;
    final_report();
  end
endmodule : dhr_reset_seq_test

bind dhr_reset_seq dhr_reset_seq_props #(.BLANK_CYC(BLANK_CYC)) props_u (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hw_reset_n(i_hw_reset_n),
  .o_display_blank(o_display_blank), .o_cancel_busy(o_cancel_busy),
  .o_sleep_in(o_sleep_in), .o_settings(o_settings), .o_cmd_valid(o_cmd_valid),
  .o_cmd(o_cmd));
`default_nettype wire

// File: verilog/dhr_reset_seq.sv
// Display hardware reset sequencer: reset pin filter, settings load, blanking, link gate.
// Behaviour
// - A low reset pulse under 5 us is ignored and one over 9 us causes a full reset.
// - A low pulse between 5 us and 9 us may start a reset with no guaranteed outcome.
// - Short spikes during a reset pulse are filtered once the reset has started; an earlier spike restarts the 5 us low count.
// - Every reset release loads the identity bytes, electrode level and trims from storage.
// - A reset taken while asleep finishes its cancel period, load included, within 5 ms.
// - A reset taken while awake finishes its cancel period within 120 ms.
// - The display is blanked during reset, and an awake blanking sequence lasts at most 120 ms.
// - A reset taken while asleep keeps the display blank throughout.
// - While reset is held all settings sit at their hardware reset defaults.
`timescale 1ns/1ps
`default_nettype none

module dhr_reset_seq #(
  parameter int unsigned BLANK_CYC = dhr_pkg::BLANK_MAX_CYC
) (
  // System clock and power-on reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Hardware reset pin from the host
  input wire logic i_hw_reset_n,
  // Serial link from the host
  input wire logic i_link_clk,
  input wire logic i_chip_select_n,
  input wire logic i_cmd_or_param_select,
  input wire logic i_sda,
  // Display and sequencing state
  output logic o_display_blank,
  output logic o_cancel_busy,
  output logic o_sleep_in,
  output dhr_pkg::dhr_settings_t o_settings,
  // Accepted bytes to the command decoder
  output logic o_cmd_valid,
  output dhr_pkg::dhr_cmd_t o_cmd
);

  typedef enum {
    ST_RUN,
    ST_HELD,
    ST_LOAD,
    ST_BLANK_WAIT
  } dhr_state_t;

  localparam logic [dhr_pkg::BLANK_W-1:0] BLANK_LAST = dhr_pkg::BLANK_W'(BLANK_CYC - 1);

  // ----------------------------------------------------------------
  // Link domain: byte assembly
  // ----------------------------------------------------------------
  // The bit counter is cleared by the frame's own select line, so a
  // clock that stops between frames leaves no half-counted byte behind.
  wire logic link_frame_rst_n = i_reset_n & ~i_chip_select_n;
  wire logic link_byte_done;

  logic [2:0] link_bit_reg;
  logic [6:0] link_shift_reg;
  logic [7:0] link_byte_reg;
  logic link_dc_reg;
  logic link_toggle_reg;

  assign link_byte_done = (link_bit_reg == dhr_pkg::LINK_BIT_LAST);

  always_ff @(posedge i_link_clk or negedge link_frame_rst_n) begin
    if (!link_frame_rst_n) begin
      link_bit_reg <= dhr_pkg::LINK_BIT_FIRST;
    end else begin
      link_bit_reg <= link_bit_reg + 3'h1;
    end
  end

  // The held byte stays stable for a whole byte time after each toggle,
  // which is far longer than the system side needs to take it.
  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_shift_reg <= 7'h00;
      link_byte_reg <= 8'h00;
      link_dc_reg <= 1'b0;
      link_toggle_reg <= 1'b0;
    end else begin
      link_shift_reg <= {link_shift_reg[5:0], i_sda};
      if (link_byte_done) begin
        link_byte_reg <= {link_shift_reg, i_sda};
        link_dc_reg <= i_cmd_or_param_select;
        link_toggle_reg <= ~link_toggle_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the system domain
  // ----------------------------------------------------------------
  logic pin_level;
  logic link_toggle_sys;

  dhr_sync3 #(
    .RESET_VAL(1'b1)
  ) u_pin_sync (
    .i_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_hw_reset_n),
    .o_level(pin_level)
  );

  dhr_sync3 #(
    .RESET_VAL(1'b0)
  ) u_toggle_sync (
    .i_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(link_toggle_reg),
    .o_level(link_toggle_sys)
  );

  logic toggle_seen_reg;
  wire logic new_byte = link_toggle_sys ^ toggle_seen_reg;

  // ----------------------------------------------------------------
  // Reset pin spike filter
  // ----------------------------------------------------------------
  // The pin must hold its new level for the whole reject time before the
  // filtered state follows, in both directions.
  logic rst_active_reg;
  logic rst_active_next;
  logic [dhr_pkg::FILT_W-1:0] filt_cnt_reg;
  logic [dhr_pkg::FILT_W-1:0] filt_cnt_next;

  wire logic pin_differs = (pin_level == rst_active_reg);
  wire logic filt_hit = pin_differs && (filt_cnt_reg == dhr_pkg::SPIKE_LAST);
  wire logic rst_start = filt_hit && !rst_active_reg;
  wire logic rst_release = filt_hit && rst_active_reg;

  always_comb begin
    rst_active_next = rst_active_reg;
    filt_cnt_next = '0;
    if (filt_hit) begin
      rst_active_next = ~rst_active_reg;
    end else if (pin_differs) begin
      filt_cnt_next = filt_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_active_reg <= 1'b0;
      filt_cnt_reg <= '0;
    end else begin
      rst_active_reg <= rst_active_next;
      filt_cnt_reg <= filt_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Settings storage
  // ----------------------------------------------------------------
  logic [7:0] nvm_mem [dhr_pkg::NVM_BYTES];

  for (genvar g = 0; g < dhr_pkg::NVM_BYTES; g++) begin : g_nvm
    assign nvm_mem[g] = dhr_pkg::NVM_IMAGE[63 - 8 * g -: 8];
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  dhr_state_t state_reg;
  dhr_state_t state_next;
  logic awake_at_reset_reg;
  logic awake_at_reset_next;
  logic [dhr_pkg::NVM_AW-1:0] nvm_idx_reg;
  logic [dhr_pkg::NVM_AW-1:0] nvm_idx_next;
  logic [dhr_pkg::BLANK_W-1:0] blank_cnt_reg;
  logic [dhr_pkg::BLANK_W-1:0] blank_cnt_next;
  dhr_pkg::dhr_settings_t settings_reg;
  dhr_pkg::dhr_settings_t settings_next;
  logic sleep_in_reg;
  logic sleep_in_next;
  logic blank_reg;
  logic blank_next;
  logic busy_reg;
  logic busy_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  dhr_pkg::dhr_cmd_t cmd_reg;
  dhr_pkg::dhr_cmd_t cmd_next;

  wire logic blank_done = (blank_cnt_reg == BLANK_LAST);
  wire logic load_last = (nvm_idx_reg == dhr_pkg::NVM_LAST);
  wire logic take_cmd = new_byte && (state_reg == ST_RUN) && !rst_start;
  wire logic is_command = take_cmd && !link_dc_reg;
  wire logic sleep_in_cmd = is_command && (link_byte_reg == dhr_pkg::CMD_SLEEP_IN);
  wire logic sleep_out_cmd = is_command && (link_byte_reg == dhr_pkg::CMD_SLEEP_OUT);

  always_comb begin
    state_next = state_reg;
    awake_at_reset_next = awake_at_reset_reg;
    nvm_idx_next = nvm_idx_reg;
    blank_cnt_next = blank_cnt_reg;
    settings_next = settings_reg;
    sleep_in_next = sleep_in_reg;
    cmd_valid_next = 1'b0;
    cmd_next = cmd_reg;

    // Blanking sequence timer runs only for a reset that caught the display awake.
    if (awake_at_reset_reg && !blank_done && (state_reg != ST_RUN)) begin
      blank_cnt_next = blank_cnt_reg + 1'b1;
    end

    if (rst_start) begin
      state_next = ST_HELD;
      awake_at_reset_next = ~sleep_in_reg;
      blank_cnt_next = '0;
      settings_next = dhr_pkg::SETTINGS_DEFAULT;
      sleep_in_next = 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (take_cmd) begin
            cmd_valid_next = 1'b1;
            cmd_next = {link_byte_reg, link_dc_reg};
          end
          if (sleep_in_cmd) begin
            sleep_in_next = 1'b1;
          end else if (sleep_out_cmd) begin
            sleep_in_next = 1'b0;
          end
        end
        ST_HELD: begin
          if (rst_release) begin
            state_next = ST_LOAD;
            nvm_idx_next = '0;
          end
        end
        ST_LOAD: begin
          settings_next = {settings_reg[55:0], nvm_mem[nvm_idx_reg]};
          nvm_idx_next = nvm_idx_reg + 1'b1;
          if (load_last) begin
            // Asleep: done right after the load, well inside 5 ms.
            if (awake_at_reset_reg && !blank_done) begin
              state_next = ST_BLANK_WAIT;
            end else begin
              state_next = ST_RUN;
            end
          end
        end
        ST_BLANK_WAIT: begin
          if (blank_done) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  // Blank while any reset step is in progress, and afterwards while asleep.
  assign blank_next = (state_next != ST_RUN) || sleep_in_next;
  assign busy_next = (state_next != ST_RUN);

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_RUN;
      awake_at_reset_reg <= 1'b0;
      nvm_idx_reg <= '0;
      blank_cnt_reg <= '0;
      toggle_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      awake_at_reset_reg <= awake_at_reset_next;
      nvm_idx_reg <= nvm_idx_next;
      blank_cnt_reg <= blank_cnt_next;
      toggle_seen_reg <= link_toggle_sys;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      settings_reg <= dhr_pkg::SETTINGS_DEFAULT;
      sleep_in_reg <= 1'b1;
      blank_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      settings_reg <= settings_next;
      sleep_in_reg <= sleep_in_next;
      blank_reg <= blank_next;
      busy_reg <= busy_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmd_valid_reg <= 1'b0;
      cmd_reg <= dhr_pkg::CMD_DEFAULT;
    end else begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_reg <= cmd_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_display_blank = blank_reg;
  assign o_cancel_busy = busy_reg;
  assign o_sleep_in = sleep_in_reg;
  assign o_settings = settings_reg;
  assign o_cmd_valid = cmd_valid_reg;
  assign o_cmd = cmd_reg;

endmodule : dhr_reset_seq

`default_nettype wire

// File: verilog/dhr_sync3.sv
// Three-stage level synchroniser that reports a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module dhr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Asynchronous level in, filtered level out
  input wire logic i_async,
  output logic o_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  wire logic agree = (s2_reg == s3_reg);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level_reg <= RESET_VAL;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign o_level = level_reg;

endmodule : dhr_sync3

`default_nettype wire
